// File: mdc_dma_control.sv
`timescale 1ns/10ps
// Summary of operation
// - overrun flag raises error irq when enabled
// - counter wrap flag raises error irq when enabled
// - single-block mode ignores both irq enables
// - command register reads always 00H
// - command 01 aborts halted channel to initial
// - command 10 clears counter and end flag
// - enable clear halts; abort halted to initial
// - transfer end returns channel to initial itself
// - release bus after all requests serviced
// - release mode: one transfer per channel unless change bit set
// - change bit selects when ownership passes
// - priority select orders channels, rotation too
// - release mode: served channel waits for group
// - second request restarts group as new tenure
// - master enable gates all; resets to 1
// - next descriptor address from pointer and base
// - buffer pointer loads buffer address register
// - length loads byte count register
// - descriptor holds pointer, buffer, length, status
// - overrun set on request at error descriptor
module mdc_dma_control #(
   parameter int NUM_CH = mdc_pkg::NUM_CH
) (
   input  wire logic                       core_clk_in,    // 25 MHz
   input  wire logic                       rst_in,         // sync, active high
   input  wire logic [mdc_pkg::ADDR_W-1:0] reg_addr_in,    // register address
   input  wire logic [mdc_pkg::DATA_W-1:0] reg_wdata_in,   // write data
   input  wire logic                       reg_wr_in,      // write strobe
   input  wire logic                       reg_rd_in,      // read strobe
   output logic      [mdc_pkg::DATA_W-1:0] reg_rdata_out,  // read data, next cycle
   input  wire logic [NUM_CH-1:0]          xfer_req_in,    // serial channel requests
   input  wire logic                       xfer_done_in,   // granted cycle finished
   input  wire logic [NUM_CH-1:0]          xfer_end_in,    // transfer end condition
   input  wire logic [NUM_CH-1:0]          frame_wrap_in,  // frame counter wrapped
   input  wire logic [NUM_CH-1:0]          frame_end_in,   // frame completed
   input  wire mdc_pkg::mdc_load_s [NUM_CH-1:0] load_in,   // descriptor load pulses
   input  wire mdc_pkg::mdc_desc_s         desc_in,        // fetched descriptor
   input  wire logic [7:0]                 link_pointer_base_in,
   input  wire logic [23:0]                error_descriptor_addr_in [NUM_CH],
   output logic      [NUM_CH-1:0]          bus_req_out,    // bus mastership wanted
   output logic      [NUM_CH-1:0]          grant_out,      // channel owning the bus
   output logic      [NUM_CH-1:0]          chan_active_out,// enabled and master on
   output logic      [NUM_CH-1:0]          channel_error_irq_out,
   output logic      [23:0]                current_descriptor_addr_out [NUM_CH],
   output logic      [23:0]                buffer_addr_out [NUM_CH],
   output logic      [15:0]                byte_count_reg_out [NUM_CH]
);

   // per-channel state
   mdc_pkg::mdc_state_e state_q [NUM_CH];          // initial / enabled / halted
   logic [7:0]          irq_en_q [NUM_CH];         // overrun/counter enables
   logic [7:0]          mode_q [NUM_CH];           // channel_mode_reg
   logic [NUM_CH-1:0]   enable_q;                  // channel_enable_bit
   logic [NUM_CH-1:0]   overrun_q;                 // buffer_overrun_flag
   logic [NUM_CH-1:0]   wrap_q;                    // counter_wrap_flag
   logic [NUM_CH-1:0]   eom_q;                     // end_of_message_flag
   logic [3:0]          frame_cnt_q [NUM_CH];      // frame_end_counter
   // shared registers
   logic [7:0]          prio_q;                    // priority_control
   logic [7:0]          master_q;                  // master_enable
   // arbitration
   logic [NUM_CH-1:0]   grant_q;                   // current owner, one-hot
   logic [NUM_CH-1:0]   served_q;                  // done first transfer this tenure
   logic [1:0]          rot_q;                     // rotation start channel
   logic                own_q;                     // bus tenure active
   logic [7:0]          rdata_q;

   // decoded write helpers
   logic                ch_hit;
   logic [1:0]          ch_sel;
   logic [1:0]          ch_reg;
   assign ch_hit = (reg_addr_in < mdc_pkg::OFS_PRIORITY);
   assign ch_sel = reg_addr_in[3:2];
   assign ch_reg = reg_addr_in[1:0];

   logic [NUM_CH-1:0] abort_cmd;    // software abort pulse per channel
   logic [NUM_CH-1:0] clr_cmd;      // counter clear pulse per channel
   logic [NUM_CH-1:0] st_wr;        // status write per channel
   logic [NUM_CH-1:0] mode_wr;
   logic [NUM_CH-1:0] ien_wr;
   logic              master_on;
   assign master_on = master_q[mdc_pkg::BIT_MASTER];

   always_comb begin
      for (int c = 0; c < NUM_CH; c++) begin
         logic hit;
         hit = reg_wr_in && ch_hit && (ch_sel == 2'(c));
         abort_cmd[c] = hit && (ch_reg == mdc_pkg::OFS_COMMAND) &&
                        (reg_wdata_in[1:0] == mdc_pkg::CMD_ABORT);
         clr_cmd[c]   = hit && (ch_reg == mdc_pkg::OFS_COMMAND) &&
                        (reg_wdata_in[1:0] == mdc_pkg::CMD_CLR_CNT);
         st_wr[c]     = hit && (ch_reg == mdc_pkg::OFS_STATUS);
         mode_wr[c]   = hit && (ch_reg == mdc_pkg::OFS_MODE);
         ien_wr[c]    = hit && (ch_reg == mdc_pkg::OFS_IRQ_EN);
      end
   end

   // channel state machine and enable bit
   always_ff @(posedge core_clk_in) begin
      for (int c = 0; c < NUM_CH; c++) begin
         if (rst_in) begin
            state_q[c]  <= mdc_pkg::MDC_INITIAL;
            enable_q[c] <= 1'b0;
         end else begin
            case (state_q[c])
               mdc_pkg::MDC_INITIAL: begin
                  // enable only through write gate low
                  if (st_wr[c] && !reg_wdata_in[mdc_pkg::BIT_WGATE] &&
                      reg_wdata_in[mdc_pkg::BIT_ENABLE]) begin
                     enable_q[c] <= 1'b1;
                     state_q[c]  <= mdc_pkg::MDC_ENABLED;
                  end
               end
               mdc_pkg::MDC_ENABLED: begin
                  if (xfer_end_in[c]) begin
                     // end condition clears enable, no abort needed
                     enable_q[c] <= 1'b0;
                     state_q[c]  <= mdc_pkg::MDC_INITIAL;
                  end else if (st_wr[c] && !reg_wdata_in[mdc_pkg::BIT_WGATE] &&
                               !reg_wdata_in[mdc_pkg::BIT_ENABLE]) begin
                     // abort is ignored here: no direct path to initial
                     enable_q[c] <= 1'b0;
                     state_q[c]  <= mdc_pkg::MDC_HALTED;
                  end
               end
               mdc_pkg::MDC_HALTED: begin
                  if (abort_cmd[c]) begin
                     state_q[c] <= mdc_pkg::MDC_INITIAL;
                  end else if (st_wr[c] && !reg_wdata_in[mdc_pkg::BIT_WGATE] &&
                               reg_wdata_in[mdc_pkg::BIT_ENABLE]) begin
                     // resumes with retained internal state
                     enable_q[c] <= 1'b1;
                     state_q[c]  <= mdc_pkg::MDC_ENABLED;
                  end
               end
               default: state_q[c] <= mdc_pkg::MDC_INITIAL;
            endcase
         end
      end
   end

   // irq enable and mode registers; kept across abort
   always_ff @(posedge core_clk_in) begin
      for (int c = 0; c < NUM_CH; c++) begin
         if (rst_in) begin
            irq_en_q[c] <= mdc_pkg::RST_ZERO;
            mode_q[c]   <= mdc_pkg::RST_ZERO;
         end else begin
            if (ien_wr[c]) begin
               irq_en_q[c] <= reg_wdata_in & mdc_pkg::IRQ_EN_MASK;
            end
            // mode changes are trusted to come only in initial state
            if (mode_wr[c]) begin
               mode_q[c] <= reg_wdata_in & mdc_pkg::MODE_MASK;
            end
         end
      end
   end

   // status flags and frame counter; set beats software clear
   always_ff @(posedge core_clk_in) begin
      for (int c = 0; c < NUM_CH; c++) begin
         logic chained;
         logic ovr_set;
         chained = mode_q[c][mdc_pkg::BIT_CHAINED];
         ovr_set = chained && xfer_req_in[c] && (state_q[c] == mdc_pkg::MDC_ENABLED) &&
                   (current_descriptor_addr_out[c] == error_descriptor_addr_in[c]);
         if (rst_in) begin
            overrun_q[c]   <= 1'b0;
            wrap_q[c]      <= 1'b0;
            eom_q[c]       <= 1'b0;
            frame_cnt_q[c] <= mdc_pkg::CNT_ZERO;
         end else begin
            if (ovr_set) begin
               overrun_q[c] <= 1'b1;
            end else if (st_wr[c] && reg_wdata_in[mdc_pkg::BIT_OVR]) begin
               overrun_q[c] <= 1'b0;
            end
            if (chained && frame_wrap_in[c]) begin
               wrap_q[c] <= 1'b1;
            end else if (st_wr[c] && reg_wdata_in[mdc_pkg::BIT_CNT]) begin
               wrap_q[c] <= 1'b0;
            end
            if (frame_end_in[c]) begin
               eom_q[c]       <= 1'b1;
               frame_cnt_q[c] <= frame_cnt_q[c] + 4'h1;
            end else if (clr_cmd[c]) begin
               eom_q[c]       <= 1'b0;
               frame_cnt_q[c] <= mdc_pkg::CNT_ZERO;
            end
         end
      end
   end

   // error interrupt: or of enabled flags, chained mode only
   always_comb begin
      for (int c = 0; c < NUM_CH; c++) begin
         logic chained;
         chained = mode_q[c][mdc_pkg::BIT_CHAINED];
         channel_error_irq_out[c] = chained &&
            ((overrun_q[c] && irq_en_q[c][mdc_pkg::BIT_OVR_EN]) ||
             (wrap_q[c]    && irq_en_q[c][mdc_pkg::BIT_CNT_EN]));
      end
   end

   // master enable gates every channel
   assign chan_active_out = enable_q & {NUM_CH{master_on}};
   logic [NUM_CH-1:0] pend;
   assign pend = xfer_req_in & chan_active_out;

   // priority order table
   function automatic logic [1:0] order_at(input logic [2:0] sel,
                                           input logic [1:0] rot,
                                           input logic [1:0] pos);
      logic [7:0] tbl;
      case (sel)
         3'h0: tbl = 8'hE4;   // 0 1 2 3
         3'h1: tbl = 8'h4E;   // 2 3 0 1
         3'h2: tbl = 8'hD8;   // 0 2 1 3
         3'h3: tbl = 8'h8D;   // 1 3 0 2
         default: tbl = 8'hE4;
      endcase
      if (sel[mdc_pkg::BIT_ROTATE]) begin
         order_at = 2'(rot + pos);
      end else begin
         order_at = tbl[2*pos +: 2];
      end
   endfunction

   // pick next owner
   logic [NUM_CH-1:0] pick;
   logic              bus_release_cond;
   logic              ccc;
   assign bus_release_cond = prio_q[mdc_pkg::BIT_BRC];
   assign ccc = prio_q[mdc_pkg::BIT_CCC];
   always_comb begin
      logic [NUM_CH-1:0] cand;
      logic [1:0]        ch;
      pick = '0;
      ch   = 2'h0;
      // in release mode only unserved channels compete; channels already served
      // this tenure thus wait until the rest of the group is through
      cand = bus_release_cond ? (pend & ~served_q) : pend;
      for (int p = NUM_CH - 1; p >= 0; p--) begin
         ch = order_at(prio_q[2:0], rot_q, 2'(p));
         if (cand[ch]) begin
            pick = '0;
            pick[ch] = 1'b1;
         end
      end
   end

   // arbitration sequencing; switches on the done pulse unless ccc keeps a still-requesting owner, or when the owner drops its request
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         grant_q  <= '0;
         served_q <= '0;
         rot_q    <= 2'h0;
         own_q    <= 1'b0;
      end else if (grant_q == '0) begin
         if (pick != '0) begin
            grant_q <= pick;
            own_q   <= 1'b1;
         end else if (served_q != '0 && (pend & ~served_q) == '0) begin
            if ((pend & served_q) != '0) begin
               served_q <= '0;
            end else begin
               served_q <= '0;
               own_q    <= 1'b0;
            end
         end else if (pend == '0) begin
            own_q <= 1'b0;
         end
      end else if (xfer_done_in) begin
         for (int c = 0; c < NUM_CH; c++) begin
            if (grant_q[c]) begin
               rot_q <= 2'(c + 1);
            end
         end
         if (bus_release_cond) begin
            served_q <= served_q | grant_q;
            // keep channel while it still asks, if ccc set
            if (!(ccc && (pend & grant_q) != '0)) begin
               grant_q <= '0;
            end
         end else if (!ccc || (pend & grant_q) == '0) begin
            grant_q <= '0;
         end
      end else if ((pend & grant_q) == '0) begin
         grant_q <= '0;
      end
   end
   assign grant_out   = grant_q;
   assign bus_req_out = {NUM_CH{own_q}} | pend;

   // descriptor loads into address and count registers
   always_ff @(posedge core_clk_in) begin
      for (int c = 0; c < NUM_CH; c++) begin
         if (rst_in) begin
            current_descriptor_addr_out[c] <= '0;
            buffer_addr_out[c]             <= '0;
            byte_count_reg_out[c]          <= '0;
         end else begin
            if (load_in[c].load_switch) begin
               current_descriptor_addr_out[c] <=
                  {link_pointer_base_in, desc_in.next_link_pointer};
            end
            if (load_in[c].load_start || load_in[c].load_switch) begin
               buffer_addr_out[c]    <= desc_in.buffer_start_pointer;
               byte_count_reg_out[c] <= desc_in.buffer_length;
            end
         end
      end
   end

   // shared registers, byte wide
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         prio_q   <= mdc_pkg::RST_ZERO;
         master_q <= mdc_pkg::RST_MASTER;
      end else if (reg_wr_in) begin
         if (reg_addr_in == mdc_pkg::OFS_PRIORITY) begin
            prio_q <= {3'h0, reg_wdata_in[4:0]};
         end
         if (reg_addr_in == mdc_pkg::OFS_MASTER) begin
            master_q <= reg_wdata_in & mdc_pkg::RST_MASTER;
         end
      end
   end

   // read mux, data one cycle after the strobe
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         rdata_q <= mdc_pkg::RST_ZERO;
      end else if (reg_rd_in) begin
         rdata_q <= mdc_pkg::RST_ZERO;
         if (ch_hit) begin
            case (ch_reg)
               mdc_pkg::OFS_IRQ_EN:
                  rdata_q <= mode_q[ch_sel][mdc_pkg::BIT_CHAINED] ? irq_en_q[ch_sel]
                             : mdc_pkg::UNDEF_READ;
               mdc_pkg::OFS_COMMAND: rdata_q <= mdc_pkg::RST_ZERO;
               mdc_pkg::OFS_MODE:    rdata_q <= mode_q[ch_sel];
               mdc_pkg::OFS_STATUS:
                  rdata_q <= {eom_q[ch_sel], 1'b0, overrun_q[ch_sel], wrap_q[ch_sel],
                              2'h0, enable_q[ch_sel], 1'b1};
               default: rdata_q <= mdc_pkg::RST_ZERO;
            endcase
         end else if (reg_addr_in == mdc_pkg::OFS_PRIORITY) begin
            rdata_q <= prio_q;
         end else if (reg_addr_in == mdc_pkg::OFS_MASTER) begin
            rdata_q <= master_q;
         end else if (reg_addr_in == mdc_pkg::OFS_STATE) begin
            rdata_q <= {state_q[3][1:0], state_q[2][1:0], state_q[1][1:0], state_q[0][1:0]};
         end
      end
   end
   assign reg_rdata_out = rdata_q;

endmodule

// File: mdc_dma_control_checker.sv
`timescale 1ns/10ps
// watches only the top ports of the dma control block
module mdc_dma_control_checker #(
   parameter int NUM_CH = mdc_pkg::NUM_CH
) (
   input wire logic                            core_clk_in,
   input wire logic                            rst_in,
   input wire logic [mdc_pkg::ADDR_W-1:0]      reg_addr_in,
   input wire logic [mdc_pkg::DATA_W-1:0]      reg_wdata_in,
   input wire logic                            reg_wr_in,
   input wire logic                            reg_rd_in,
   input wire logic [mdc_pkg::DATA_W-1:0]      reg_rdata_out,
   input wire logic [NUM_CH-1:0]               xfer_end_in,
   input wire mdc_pkg::mdc_load_s [NUM_CH-1:0] load_in,
   input wire mdc_pkg::mdc_desc_s              desc_in,
   input wire logic [7:0]                      link_pointer_base_in,
   input wire logic [NUM_CH-1:0]               grant_out,
   input wire logic [NUM_CH-1:0]               chan_active_out,
   input wire logic [NUM_CH-1:0]               channel_error_irq_out,
   input wire logic [23:0]                     current_descriptor_addr_out [NUM_CH],
   input wire logic [23:0]                     buffer_addr_out [NUM_CH],
   input wire logic [15:0]                     byte_count_reg_out [NUM_CH]
);
   logic master_q;  // shadow of the master enable bit
   // shadow follows software writes, so the gate check needs no internal probe
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         master_q <= 1'b1;
      end else if (reg_wr_in && reg_addr_in == mdc_pkg::OFS_MASTER) begin
         master_q <= reg_wdata_in[mdc_pkg::BIT_MASTER];
      end
   end
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (rst_in);
   cmd_reads_zero_a : assert property (reg_rd_in && reg_addr_in < 8'h10 &&
      reg_addr_in[1:0] == mdc_pkg::OFS_COMMAND |=> reg_rdata_out == 8'h00) else $error("command read not zero");
   unmapped_zero_a : assert property (reg_rd_in && reg_addr_in > mdc_pkg::OFS_STATE
      |=> reg_rdata_out == 8'h00) else $error("unmapped read not zero");
   rdata_hold_a : assert property (!$past(reg_rd_in) && !$past(rst_in) |-> $stable(reg_rdata_out))
      else $error("read data moved without a read");
   grant_onehot_a : assert property ($onehot0(grant_out)) else $error("grant not one-hot");
   master_gate_a : assert property (!master_q |-> chan_active_out == '0)
      else $error("channel active with master off");
   end_clears_a : assert property (xfer_end_in[0] && chan_active_out[0]
      |=> !chan_active_out[0]) else $error("transfer end left channel active");
   buf_load_a : assert property (load_in[0].load_start |=> buffer_addr_out[0] ==
      $past(desc_in.buffer_start_pointer) && byte_count_reg_out[0] == $past(desc_in.buffer_length))
      else $error("start load wrong");
   link_load_a : assert property (load_in[0].load_switch |=> current_descriptor_addr_out[0] ==
      {$past(link_pointer_base_in), $past(desc_in.next_link_pointer)}) else $error("link load wrong");
   reset_quiet_a : assert property ($fell(rst_in) |-> grant_out == '0 && channel_error_irq_out == '0)
      else $error("outputs not quiet after reset");
   cover property (grant_out != '0);
   cover property (channel_error_irq_out[3]);
   cover property (load_in[0].load_switch);
endmodule
bind mdc_dma_control mdc_dma_control_checker #(.NUM_CH(NUM_CH)) mdc_dma_control_checker_inst (
   .core_clk_in(core_clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
   .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
   .reg_rdata_out(reg_rdata_out), .xfer_end_in(xfer_end_in), .load_in(load_in),
   .desc_in(desc_in), .link_pointer_base_in(link_pointer_base_in), .grant_out(grant_out),
   .chan_active_out(chan_active_out), .channel_error_irq_out(channel_error_irq_out),
   .current_descriptor_addr_out(current_descriptor_addr_out),
   .buffer_addr_out(buffer_addr_out), .byte_count_reg_out(byte_count_reg_out));

// File: mdc_dma_control_tb_top.sv
`timescale 1ns/10ps
module mdc_dma_control_tb_top;
   logic               core_clk = 1'b0;
   logic               rst = 1'b1;
   logic               wr_s = 1'b0, rd_s = 1'b0, slow = 1'b0;
   logic               done;
   logic [7:0]         addr = 8'h00, wdata = 8'h00;
   logic [7:0]         rdata, base = 8'hA5;
   logic [3:0]         req = 4'h0, xend = 4'h0, wrap = 4'h0, fend = 4'h0;
   logic [3:0]         breq, grant, act, irq;
   logic [3:0]         first [4] = '{4'h1, 4'h4, 4'h1, 4'h2};
   mdc_pkg::mdc_load_s [3:0] load = '0;
   mdc_pkg::mdc_desc_s desc;
   logic [23:0]        eda [4] = '{default: 24'hFFFFFF};
   logic [23:0]        cda [4], bar [4];
   logic [15:0]        byte_count_reg [4];
   int                 miscompares = 0;
   int                 checks_done = 0;
   int                 cycles = 0;
   always #20 core_clk = ~core_clk;
   mdc_mem_model mdc_mem_model_inst (.core_clk_in(core_clk), .rst_in(rst), .grant_in(grant),
      .slow_in(slow), .done_out(done), .desc_out(desc));
   mdc_dma_control mdc_dma_control_inst (.core_clk_in(core_clk), .rst_in(rst),
      .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr_s), .reg_rd_in(rd_s),
      .reg_rdata_out(rdata), .xfer_req_in(req), .xfer_done_in(done), .xfer_end_in(xend),
      .frame_wrap_in(wrap), .frame_end_in(fend), .load_in(load), .desc_in(desc),
      .link_pointer_base_in(base), .error_descriptor_addr_in(eda), .bus_req_out(breq),
      .grant_out(grant), .chan_active_out(act), .channel_error_irq_out(irq),
      .current_descriptor_addr_out(cda), .buffer_addr_out(bar), .byte_count_reg_out(byte_count_reg));
   task automatic stop_test;
      if (miscompares == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t %s got %0h exp %0h", $time, msg, got, exp);
      end
   endtask
   function automatic logic [7:0] ra(input int c, input int o);
      return 8'(c * 4 + o);  // per-channel block of four bytes
   endfunction
   // strobe drops and a clock passes between calls
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      addr  <= a;
      wdata <= d;
      wr_s  <= 1'b1;
      @(posedge core_clk);
      wr_s  <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] msk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge core_clk);
      rd_s <= 1'b0;
      @(negedge core_clk);
      chk(rdata & msk, exp, "register read");
      @(posedge core_clk);
   endtask
   // bounded wait for a new owner, skipping idle gaps and the previous owner
   task automatic wait_grant(input logic [3:0] exp, input logic [3:0] last);
      for (int i = 0; i < 40 && grant !== exp && (exp == 4'h0 || grant === 4'h0 ||
           grant === last); i++) @(negedge core_clk);
      chk(grant, exp, "bus owner");
      @(posedge core_clk);
   endtask
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         stop_test();
      end
   end
   initial begin
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      rd(mdc_pkg::OFS_MASTER, 8'h80, 8'hFF);
      rd(mdc_pkg::OFS_STATE, 8'h00, 8'hFF);
      rd(8'h3C, 8'h00, 8'hFF);
      for (int c = 0; c < 4; c++) begin
         wr(ra(c, 2), 8'h10);
         wr(ra(c, 0), 8'h30);
         rd(ra(c, 0), 8'h30, 8'hFF);
         rd(ra(c, 1), 8'h00, 8'hFF);
         wr(ra(c, 3), 8'h02);
      end
      chk(act, 4'hF, "all active");
      rd(mdc_pkg::OFS_STATE, 8'h55, 8'hFF);
      wr(ra(0, 3), 8'h01);
      chk(act[0], 1'b1, "gated enable write");
      wr(mdc_pkg::OFS_MASTER, 8'h00);
      chk(act, 4'h0, "master off");
      wr(mdc_pkg::OFS_MASTER, 8'h80);
      foreach (first[i]) begin
         wr(mdc_pkg::OFS_PRIORITY, 8'(i));
         req <= 4'hF;
         wait_grant(first[i], 4'h0);
         chk(breq, 4'hF, "bus wanted");
         req <= 4'h0;
         wait_grant(4'h0, 4'h0);
      end
      wr(mdc_pkg::OFS_PRIORITY, 8'h10);
      req <= 4'h3;
      wait_grant(4'h1, 4'h0);
      wait_grant(4'h2, 4'h1);
      req <= 4'h0;
      wait_grant(4'h0, 4'h0);
      wr(mdc_pkg::OFS_PRIORITY, 8'h08);
      slow <= 1'b1;
      req  <= 4'h3;
      wait_grant(4'h1, 4'h0);
      repeat (12) begin
         @(negedge core_clk);
         chk(grant[1], 1'b0, "owner kept while requesting");
      end
      @(posedge core_clk);
      req <= 4'h2;
      wait_grant(4'h2, 4'h1);
      req <= 4'h0;
      wait_grant(4'h0, 4'h0);
      load[0] <= 2'b10;
      @(posedge core_clk);
      load[0] <= 2'b01;
      @(posedge core_clk);
      load[0] <= 2'b00;
      @(negedge core_clk);
      chk(bar[0], 24'hABCDEF, "buffer address");
      chk(byte_count_reg[0], 16'h0321, "byte count");
      chk(cda[0], {base, 16'h1234}, "descriptor address");
      @(posedge core_clk);
      xend <= 4'h1;
      @(posedge core_clk);
      xend <= 4'h0;
      rd(mdc_pkg::OFS_STATE, 8'h00, 8'h03);
      chk(act[0], 1'b0, "ended channel idle");
      wr(ra(1, 3), 8'h00);
      rd(mdc_pkg::OFS_STATE, 8'h08, 8'h0C);
      wr(ra(1, 1), {6'h00, mdc_pkg::CMD_ABORT});
      rd(mdc_pkg::OFS_STATE, 8'h00, 8'h0C);
      rd(ra(1, 2), 8'h10, 8'hFF);
      rd(ra(1, 0), 8'h30, 8'hFF);
      wr(ra(2, 1), {6'h00, mdc_pkg::CMD_ABORT});
      rd(mdc_pkg::OFS_STATE, 8'h10, 8'h30);
      fend <= 4'h4;
      @(posedge core_clk);
      fend <= 4'h0;
      rd(ra(2, 3), 8'h80, 8'h80);
      wr(ra(2, 1), {6'h00, mdc_pkg::CMD_CLR_CNT});
      rd(ra(2, 3), 8'h00, 8'h80);
      wrap <= 4'h8;
      @(posedge core_clk);
      wrap <= 4'h0;
      @(posedge core_clk);
      chk(irq[3], 1'b1, "wrap irq");
      wr(ra(3, 0), 8'h20);
      chk(irq[3], 1'b0, "wrap irq masked");
      wr(ra(3, 0), 8'h30);
      wr(ra(3, 3), 8'h11);
      chk(irq[3], 1'b0, "wrap cleared");
      eda[3] <= 24'h000000;
      req    <= 4'h8;
      @(posedge core_clk);
      req    <= 4'h0;
      eda[3] <= 24'hFFFFFF;
      rd(ra(3, 3), 8'h20, 8'h20);
      chk(irq[3], 1'b1, "overrun irq");
      wr(ra(3, 3), 8'h00);
      wr(ra(3, 1), {6'h00, mdc_pkg::CMD_ABORT});
      wr(ra(3, 2), 8'h00);
      rd(ra(3, 0), 8'h00, 8'hFF);
      chk(irq[3], 1'b0, "single mode irq");
      stop_test();
   end
endmodule

// File: mdc_mem_model.sv
`timescale 1ns/10ps
// stands in for memory and transfer engine: finishes each granted cycle
module mdc_mem_model (
   input  wire logic         core_clk_in,
   input  wire logic         rst_in,
   input  wire logic [3:0]   grant_in,   // current bus owner
   input  wire logic         slow_in,    // stretch each transfer cycle
   output logic              done_out,   // one-cycle completion pulse
   output mdc_pkg::mdc_desc_s desc_out   // descriptor as laid out in memory
);
   logic [3:0] wait_q;  // cycles spent in the current transfer
   // completion comes two or six cycles after grant, never while idle
   always_ff @(posedge core_clk_in) begin
      if (rst_in || grant_in == 4'h0 || done_out) begin
         wait_q   <= 4'h0;
         done_out <= 1'b0;
      end else begin
         wait_q   <= wait_q + 4'h1;
         done_out <= (wait_q == (slow_in ? 4'h5 : 4'h1));
      end
   end
   // fixed transmit descriptor: link, buffer, length, status fields
   assign desc_out = '{16'h1234, 24'hABCDEF, 16'h0321, 8'h80};
endmodule

// File: mdc_pkg.sv
package mdc_pkg;
   // channel count and widths
   localparam int NUM_CH        = 4;
   localparam int ADDR_W        = 8;
   localparam int DATA_W        = 8;
   // register offsets: per-channel block of four bytes, shared regs above
   localparam logic [7:0] OFS_CH_BASE   = 8'h00;  // channel n at n*4
   localparam logic [1:0] OFS_IRQ_EN    = 2'h0;   // channel_irq_enable
   localparam logic [1:0] OFS_COMMAND   = 2'h1;   // channel_command
   localparam logic [1:0] OFS_MODE      = 2'h2;   // channel_mode_reg
   localparam logic [1:0] OFS_STATUS    = 2'h3;   // channel status
   localparam logic [7:0] OFS_PRIORITY  = 8'h10;  // priority_control
   localparam logic [7:0] OFS_MASTER    = 8'h11;  // master_enable
   localparam logic [7:0] OFS_STATE     = 8'h12;  // channel states, read only
   // irq enable field positions
   localparam int BIT_OVR_EN    = 5;
   localparam int BIT_CNT_EN    = 4;
   // status field positions
   localparam int BIT_EOM       = 7;
   localparam int BIT_OVR       = 5;
   localparam int BIT_CNT       = 4;
   localparam int BIT_ENABLE    = 1;
   localparam int BIT_WGATE     = 0;
   // mode field
   localparam int BIT_CHAINED   = 4;
   // priority control fields
   localparam int BIT_BRC       = 4;
   localparam int BIT_CCC       = 3;
   localparam int BIT_ROTATE    = 2;
   // master enable
   localparam int BIT_MASTER    = 7;
   // command codes
   localparam logic [1:0] CMD_ABORT     = 2'h1;
   localparam logic [1:0] CMD_CLR_CNT   = 2'h2;
   // reset values and write masks
   localparam logic [7:0] RST_MASTER    = 8'h80;
   localparam logic [7:0] RST_ZERO      = 8'h00;
   localparam logic [3:0] CNT_ZERO      = 4'h0;
   localparam logic [7:0] IRQ_EN_MASK   = 8'hF0;
   localparam logic [7:0] MODE_MASK     = 8'h16;
   // undefined reads of single-block reserved bits return zero here
   localparam logic [7:0] UNDEF_READ    = 8'h00;

   typedef enum logic [1:0] {
      MDC_INITIAL,
      MDC_ENABLED,
      MDC_HALTED
   } mdc_state_e;

   // transmit descriptor as read from memory
   typedef struct packed {
      logic [15:0] next_link_pointer;
      logic [23:0] buffer_start_pointer;
      logic [15:0] buffer_length;
      logic [7:0]  descriptor_status;
   } mdc_desc_s;

   // per-channel load pulse group from the transfer engine
   typedef struct packed {
      logic       load_start;   // transfer start
      logic       load_switch;  // buffer switching
   } mdc_load_s;
endpackage
